// File: src/pvao_pkg.sv
package pvao_pkg;
  // data and port widths
  localparam int VAL_W = 16;
  localparam int ADDR_W = 4;
  localparam int NKEY = 5;
  localparam int NRELAY = 4;
  localparam int SCALE_FRAC = 8;
  localparam int GAIN_FRAC = 15;
  localparam int DIV_STEPS = 25;
  // key bit positions in the key pin vector
  localparam int KEY_UP = 0;
  localparam int KEY_DOWN = 1;
  localparam int KEY_SETPOINT = 2;
  localparam int KEY_MENU = 3;
  localparam int KEY_RESET = 4;
  // register offsets
  localparam logic [3:0] REG_LOCK = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_LOW_DISP = 4'h2;
  localparam logic [3:0] REG_LOW_OUT = 4'h3;
  localparam logic [3:0] REG_HIGH_DISP = 4'h4;
  localparam logic [3:0] REG_HIGH_OUT = 4'h5;
  localparam logic [3:0] REG_VZ = 4'h6;
  localparam logic [3:0] REG_VG = 4'h7;
  localparam logic [3:0] REG_IZ = 4'h8;
  localparam logic [3:0] REG_IG = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'ha;
  localparam logic [3:0] REG_MAX = 4'hb;
  localparam logic [3:0] REG_MIN = 4'hc;
  localparam logic [3:0] REG_SCALE = 4'hd;
  localparam logic [3:0] REG_OFFSET = 4'he;
  localparam logic [3:0] REG_DAC = 4'hf;
  // lockout register fields
  localparam int LOCK_W = 5;
  localparam int LK_MAX = 0;
  localparam int LK_MIN = 1;
  localparam int LK_CAL = 2;
  localparam int LK_SO = 3;
  localparam int LK_TRIM = 4;
  localparam logic [4:0] LOCK_RST = 5'h1f;
  // configuration register fields
  localparam int CFG_W = 7;
  localparam int CF_OUT_EN = 0;
  localparam int CF_CAL_CUR = 1;
  localparam int CF_SRC = 2;
  localparam int CF_BCD_PEAK = 4;
  localparam int CF_RMAP = 5;
  localparam logic [6:0] CFG_RST = 7'h00;
  // reset values of the two scale points and trims
  localparam logic [15:0] LOW_DISP_RST = 16'h0000;
  localparam logic [15:0] LOW_OUT_RST = 16'h0000;
  localparam logic [15:0] HIGH_DISP_RST = 16'h1000;
  localparam logic [15:0] HIGH_OUT_RST = 16'h1000;
  localparam logic [15:0] TRIM_RST = 16'h0000;
  localparam logic signed [17:0] GAIN_ONE = 18'sh08000;
  typedef enum logic [1:0] {SRC_RAW = 2'b00, SRC_FILT = 2'b01,
    SRC_MAX = 2'b10, SRC_MIN = 2'b11} pvao_src_t;
  typedef enum logic [1:0] {VIEW_LIVE = 2'b00, VIEW_MAX = 2'b01,
    VIEW_MIN = 2'b10} pvao_view_t;
  typedef enum logic [1:0] {SC_IDLE = 2'b00, SC_DIV = 2'b01,
    SC_SCALE = 2'b10, SC_OFFS = 2'b11} pvao_sc_state_t;
endpackage

// File: src/pvao_cal_if.sv
`timescale 1ns/1ns
`default_nettype none
// scale and offset handed from the solver to the output path
interface pvao_cal_if;
  logic signed [15:0] scale;
  logic signed [15:0] offset;
  logic ready;
  modport prod(output scale, output offset, output ready);
  modport cons(input scale, input offset, input ready);
endinterface
`default_nettype wire

// File: src/pvao_scale.sv
`timescale 1ns/1ns
`default_nettype none
module pvao_scale (
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic start, // points changed
  input wire logic signed [15:0] d1, // low display point
  input wire logic signed [15:0] o1, // low output point
  input wire logic signed [15:0] d2, // high display point
  input wire logic signed [15:0] o2, // high output point
  pvao_cal_if.prod cal // solved scale and offset
);
  import pvao_pkg::*;
  pvao_sc_state_t state_reg;
  logic [24:0] num_reg, quo_reg;
  logic [17:0] rem_reg;
  logic [16:0] den_reg;
  logic [4:0] cnt_reg;
  logic neg_reg, pend_reg, ready_reg;
  logic signed [15:0] scale_reg, offset_reg;
  // span differences and their magnitudes
  wire signed [16:0] dn = 17'(o2) - 17'(o1);
  wire signed [16:0] dd = 17'(d2) - 17'(d1);
  wire [16:0] dn_mag = dn[16] ? 17'(-dn) : 17'(dn);
  wire [16:0] dd_mag = dd[16] ? 17'(-dd) : 17'(dd);
  wire [17:0] rem_sh = {rem_reg[16:0], num_reg[24]};
  wire rem_ge = rem_sh >= {1'b0, den_reg};
  // quotient clamps to 15 bits of magnitude
  wire [14:0] mag15 = (|quo_reg[24:15]) ? 15'h7fff : quo_reg[14:0];
  wire signed [15:0] scale_val = neg_reg ? -$signed({1'b0, mag15}) : $signed({1'b0, mag15});
  wire signed [31:0] sd1 = scale_reg * d1;
  wire signed [32:0] off_full = 33'(o1) - 33'(sd1 >>> SCALE_FRAC);
  wire signed [15:0] off_sat = (off_full > 33'sd32767) ? 16'sh7fff :
    (off_full < -33'sd32768) ? 16'sh8000 : off_full[15:0];
  assign cal.scale = scale_reg;
  assign cal.offset = offset_reg;
  assign cal.ready = ready_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= SC_IDLE;
      num_reg <= 25'h0000000;
      quo_reg <= 25'h0000000;
      rem_reg <= 18'h00000;
      den_reg <= 17'h00000;
      cnt_reg <= 5'h00;
      neg_reg <= 1'b0;
      pend_reg <= 1'b1;
      ready_reg <= 1'b0;
      scale_reg <= 16'sh0000;
      offset_reg <= 16'sh0000;
    end else begin
      if (start) begin
        pend_reg <= 1'b1;
      end
      case (state_reg)
        SC_IDLE: begin
          if (start || pend_reg) begin
            pend_reg <= 1'b0;
            ready_reg <= 1'b0;
            num_reg <= {dn_mag, 8'h00};
            den_reg <= dd_mag;
            neg_reg <= dn[16] ^ dd[16];
            quo_reg <= 25'h0000000;
            rem_reg <= 18'h00000;
            cnt_reg <= 5'(DIV_STEPS - 1);
            state_reg <= (dd_mag == 17'h00000) ? SC_SCALE : SC_DIV;
          end
        end
        SC_DIV: begin
          num_reg <= {num_reg[23:0], 1'b0};
          rem_reg <= rem_ge ? rem_sh - {1'b0, den_reg} : rem_sh;
          quo_reg <= {quo_reg[23:0], rem_ge};
          cnt_reg <= cnt_reg - 5'h01;
          if (cnt_reg == 5'h00) begin
            state_reg <= SC_SCALE;
          end
        end
        SC_SCALE: begin
          scale_reg <= (den_reg == 17'h00000) ? 16'sh0000 : scale_val;
          state_reg <= SC_OFFS;
        end
        SC_OFFS: begin
          offset_reg <= off_sat;
          ready_reg <= 1'b1;
          state_reg <= SC_IDLE;
        end
        default: state_reg <= SC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: src/pvao_out.sv
`timescale 1ns/1ns
`default_nettype none
module pvao_out (
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, active low
  pvao_cal_if.cons cal, // scale and offset
  input wire logic signed [15:0] level, // selected source value
  input wire logic enable, // analog output active
  input wire logic cal_current, // trim goes to current output
  input wire logic signed [15:0] v_zero, // voltage zero trim
  input wire logic signed [15:0] v_gain, // voltage gain trim
  input wire logic signed [15:0] i_zero, // current zero trim
  input wire logic signed [15:0] i_gain, // current gain trim
  output logic [15:0] v_code, // voltage converter code
  output logic [15:0] i_code // current converter code
);
  import pvao_pkg::*;
  function automatic logic [15:0] sat16(input logic signed [35:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v < 36'sd0) begin
      r = 16'h0000;
    end else if (v > 36'sd65535) begin
      r = 16'hffff;
    end
    return r;
  endfunction
  // display value to output level, then clamp
  wire signed [31:0] prod = cal.scale * level;
  wire signed [32:0] mapped = 33'(cal.offset) + 33'(prod >>> SCALE_FRAC);
  wire [15:0] raw_code = sat16(36'(mapped));
  wire signed [15:0] zero_sel = cal_current ? i_zero : v_zero;
  wire signed [15:0] gain_sel = cal_current ? i_gain : v_gain;
  wire signed [17:0] gfac = GAIN_ONE + 18'(gain_sel);
  wire signed [34:0] tprod = $signed({1'b0, raw_code}) * gfac;
  wire signed [35:0] trimmed = 36'(tprod >>> GAIN_FRAC) + 36'(zero_sel);
  wire [15:0] trim_code = sat16(trimmed);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      v_code <= 16'h0000;
      i_code <= 16'h0000;
    end else begin
      v_code <= enable ? (cal_current ? raw_code : trim_code) : 16'h0000;
      i_code <= enable ? (cal_current ? trim_code : raw_code) : 16'h0000;
    end
  end
  property p_untrimmed;
    @(posedge clk) disable iff (!nrst) (enable && cal_current) |=> v_code == $past(raw_code);
  endproperty
  a_untrimmed: assert property (p_untrimmed) else $error("voltage output trimmed");
  property p_clamp_low;
    @(posedge clk) disable iff (!nrst)
      (enable && mapped < 33'sd0 && !cal_current) |=> i_code == 16'h0000;
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("negative level wrapped");
endmodule
`default_nettype wire

// File: src/pvao_top.sv
`timescale 1ns/1ns
`default_nettype none
module pvao_top (
  input wire logic clk, // 20 MHz system clock
  input wire logic nrst, // sync reset, active low
  input wire logic [pvao_pkg::ADDR_W-1:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire logic meas_valid, // new measurement pulse
  input wire logic signed [15:0] meas_raw, // unfiltered measurement
  input wire logic signed [15:0] meas_filt, // filtered measurement
  input wire logic run_mode, // meter is in run mode
  input wire logic [pvao_pkg::NKEY-1:0] key_pin, // front keys, high when pressed
  input wire logic [pvao_pkg::NRELAY-1:0] sp_active, // setpoint active states
  output logic signed [15:0] disp_value, // value on the display
  output logic disp_flash, // display flashing
  output logic signed [15:0] bcd_value, // parallel output value
  output logic dac_enable, // analog output active
  output logic [15:0] dac_v_code, // voltage converter code
  output logic [15:0] dac_i_code, // current converter code
  output logic dac_cal_current, // calibrated output is current
  output logic [pvao_pkg::NRELAY-1:0] relay // relay coils
);
  import pvao_pkg::*;

  // key pins: two flops to settle, a third for the edge
  logic [NKEY-1:0] key_press;
  genvar gk;
  generate
    for (gk = 0; gk < NKEY; gk++) begin : g_key
      logic s1_reg, s2_reg, prev_reg;
      always_ff @(posedge clk) begin
        if (!nrst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          prev_reg <= 1'b0;
        end else begin
          s1_reg <= key_pin[gk];
          s2_reg <= s1_reg;
          prev_reg <= s2_reg;
        end
      end
      assign key_press[gk] = s2_reg & ~prev_reg;
    end
  endgenerate

  // register storage
  logic [LOCK_W-1:0] lock_reg;
  logic [CFG_W-1:0] cfg_reg;
  logic signed [15:0] low_disp_reg, low_out_reg, high_disp_reg, high_out_reg;
  logic signed [15:0] vz_reg, vg_reg, iz_reg, ig_reg;
  logic pt_wr_reg;

  // write decode with lock gating
  wire cal_open = ~lock_reg[LK_CAL];
  wire so_open = ~lock_reg[LK_SO];
  wire trim_open = ~lock_reg[LK_TRIM];
  wire wr_lock = reg_wr && (reg_addr == REG_LOCK);
  wire wr_cfg = reg_wr && (reg_addr == REG_CFG);
  wire wr_pt = reg_wr && so_open && (reg_addr >= REG_LOW_DISP) && (reg_addr <= REG_HIGH_OUT);
  wire wr_trim = reg_wr && trim_open && (reg_addr >= REG_VZ) && (reg_addr <= REG_IG);
  wire cal_bit = cal_open ? reg_wdata[CF_CAL_CUR] : cfg_reg[CF_CAL_CUR];
  wire [CFG_W-1:0] cfg_wval = {reg_wdata[CFG_W-1:CF_SRC], cal_bit, reg_wdata[CF_OUT_EN]};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_reg <= LOCK_RST;
      cfg_reg <= CFG_RST;
      low_disp_reg <= LOW_DISP_RST;
      low_out_reg <= LOW_OUT_RST;
      high_disp_reg <= HIGH_DISP_RST;
      high_out_reg <= HIGH_OUT_RST;
      pt_wr_reg <= 1'b0;
    end else begin
      pt_wr_reg <= wr_pt;
      if (wr_lock) lock_reg <= reg_wdata[LOCK_W-1:0];
      if (wr_cfg) cfg_reg <= cfg_wval;
      if (wr_pt && reg_addr == REG_LOW_DISP) low_disp_reg <= reg_wdata;
      if (wr_pt && reg_addr == REG_LOW_OUT) low_out_reg <= reg_wdata;
      if (wr_pt && reg_addr == REG_HIGH_DISP) high_disp_reg <= reg_wdata;
      if (wr_pt && reg_addr == REG_HIGH_OUT) high_out_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      vz_reg <= TRIM_RST;
      vg_reg <= TRIM_RST;
      iz_reg <= TRIM_RST;
      ig_reg <= TRIM_RST;
    end else begin
      if (wr_trim && reg_addr == REG_VZ) vz_reg <= reg_wdata;
      if (wr_trim && reg_addr == REG_VG) vg_reg <= reg_wdata;
      if (wr_trim && reg_addr == REG_IZ) iz_reg <= reg_wdata;
      if (wr_trim && reg_addr == REG_IG) ig_reg <= reg_wdata;
    end
  end

  // view state: key decode
  pvao_view_t view_reg, view_next;
  logic track_valid_reg;
  logic signed [15:0] max_reg, min_reg;
  wire view_open = run_mode && !lock_reg[LK_MAX] && !lock_reg[LK_MIN];
  wire viewing = view_reg != VIEW_LIVE;
  wire leave = key_press[KEY_SETPOINT] | key_press[KEY_MENU] | key_press[KEY_RESET];
  wire restart = viewing && key_press[KEY_RESET];
  assign view_next = (viewing && leave) ? VIEW_LIVE :
    (!viewing && view_open && key_press[KEY_UP]) ? VIEW_MAX :
    (!viewing && view_open && key_press[KEY_DOWN]) ? VIEW_MIN : view_reg;

  wire take_hi = meas_valid && !restart && (!track_valid_reg || meas_raw > max_reg);
  wire take_lo = meas_valid && !restart && (!track_valid_reg || meas_raw < min_reg);
  wire signed [15:0] max_next = take_hi ? meas_raw : max_reg;
  wire signed [15:0] min_next = take_lo ? meas_raw : min_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      track_valid_reg <= 1'b0;
      max_reg <= 16'sh0000;
      min_reg <= 16'sh0000;
    end else begin
      if (restart) begin
        track_valid_reg <= 1'b0;
      end else if (meas_valid) begin
        track_valid_reg <= 1'b1;
      end
      max_reg <= max_next;
      min_reg <= min_next;
    end
  end

  logic signed [15:0] disp_sel;
  always_comb begin
    case (view_next)
      VIEW_MAX: disp_sel = max_next;
      VIEW_MIN: disp_sel = min_next;
      VIEW_LIVE: disp_sel = meas_raw;
      default: disp_sel = meas_raw;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      view_reg <= VIEW_LIVE;
      disp_value <= 16'sh0000;
      disp_flash <= 1'b0;
    end else begin
      view_reg <= view_next;
      disp_value <= disp_sel;
      disp_flash <= view_next != VIEW_LIVE;
    end
  end

  wire [1:0] src_sel = cfg_reg[CF_SRC+1:CF_SRC];
  wire signed [15:0] ana_level = (src_sel == SRC_RAW) ? meas_raw :
    (src_sel == SRC_FILT) ? meas_filt : (src_sel == SRC_MAX) ? max_reg : min_reg;
  wire cal_cur = cfg_reg[CF_CAL_CUR];
  wire en_next = cfg_reg[CF_OUT_EN] && run_mode;
  wire signed [15:0] bcd_next = cfg_reg[CF_BCD_PEAK] ? max_reg : meas_raw;

  // relay routing: four fixed permutations
  wire [1:0] rmap = cfg_reg[CF_RMAP+1:CF_RMAP];
  logic [NRELAY-1:0] relay_next;
  always_comb begin
    case (rmap)
      2'h0: relay_next = sp_active;
      2'h1: relay_next = {sp_active[3], sp_active[0], sp_active[1], sp_active[2]};
      2'h2: relay_next = {sp_active[1], sp_active[0], sp_active[3], sp_active[2]};
      2'h3: relay_next = {sp_active[1], sp_active[2], sp_active[3], sp_active[0]};
      default: relay_next = sp_active;
    endcase
  end

  // registered outputs; enable lags config by one cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dac_enable <= 1'b0;
      dac_cal_current <= 1'b0;
      bcd_value <= 16'sh0000;
      relay <= '0;
    end else begin
      dac_enable <= en_next;
      dac_cal_current <= cal_cur;
      bcd_value <= bcd_next;
      relay <= relay_next;
    end
  end

  // scale solver and output path
  pvao_cal_if cal_if();
  pvao_scale u_scale (
    .clk(clk),
    .nrst(nrst),
    .start(pt_wr_reg),
    .d1(low_disp_reg),
    .o1(low_out_reg),
    .d2(high_disp_reg),
    .o2(high_out_reg),
    .cal(cal_if.prod)
  );
  pvao_out u_out (
    .clk(clk),
    .nrst(nrst),
    .cal(cal_if.cons),
    .level(ana_level),
    .enable(dac_enable),
    .cal_current(dac_cal_current),
    .v_zero(vz_reg),
    .v_gain(vg_reg),
    .i_zero(iz_reg),
    .i_gain(ig_reg),
    .v_code(dac_v_code),
    .i_code(dac_i_code)
  );

  // read mux; unmapped never occurs, all 16 offsets used
  wire [15:0] status = {11'h000, cal_if.ready, track_valid_reg, disp_flash, view_reg};
  wire [15:0] rd_mux = (reg_addr == REG_LOCK) ? {11'h000, lock_reg} :
    (reg_addr == REG_CFG) ? {9'h000, cfg_reg} :
    (reg_addr == REG_LOW_DISP) ? low_disp_reg :
    (reg_addr == REG_LOW_OUT) ? low_out_reg :
    (reg_addr == REG_HIGH_DISP) ? high_disp_reg :
    (reg_addr == REG_HIGH_OUT) ? high_out_reg :
    (reg_addr == REG_VZ) ? vz_reg : (reg_addr == REG_VG) ? vg_reg :
    (reg_addr == REG_IZ) ? iz_reg : (reg_addr == REG_IG) ? ig_reg :
    (reg_addr == REG_STATUS) ? status : (reg_addr == REG_MAX) ? max_reg :
    (reg_addr == REG_MIN) ? min_reg : (reg_addr == REG_SCALE) ? cal_if.scale :
    (reg_addr == REG_OFFSET) ? cal_if.offset : dac_v_code;

  // data valid only the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_max_track;
    (meas_valid && track_valid_reg && !restart && meas_raw > max_reg)
      |=> max_reg == $past(meas_raw);
  endproperty
  a_max_track: assert property (p_max_track) else $error("max not replaced");
  property p_disp_follow;
    (view_reg == VIEW_MIN && !leave && take_lo) |=> disp_value == min_reg;
  endproperty
  a_disp_follow: assert property (p_disp_follow) else $error("display lags min");
  property p_flash;
    (view_reg != VIEW_LIVE) |-> disp_flash ##0 (disp_value == max_reg || disp_value == min_reg);
  endproperty
  a_flash: assert property (p_flash) else $error("extreme shown without flash");
  property p_keep;
    (viewing && key_press[KEY_MENU] && !meas_valid)
      |=> view_reg == VIEW_LIVE && max_reg == $past(max_reg)
        && track_valid_reg == $past(track_valid_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("menu key lost extremes");
  property p_restart;
    restart |=> !track_valid_reg && view_reg == VIEW_LIVE && !disp_flash;
  endproperty
  a_restart: assert property (p_restart) else $error("reset key did not restart");
  property p_view_lock;
    (view_reg == VIEW_LIVE && (lock_reg[LK_MAX] || lock_reg[LK_MIN])) |=> view_reg == VIEW_LIVE;
  endproperty
  a_view_lock: assert property (p_view_lock) else $error("locked view entered");
  property p_bcd;
    1'b1 |=> bcd_value == ($past(cfg_reg[CF_BCD_PEAK]) ? $past(max_reg) : $past(meas_raw));
  endproperty
  a_bcd: assert property (p_bcd) else $error("parallel source wrong");
  property p_enable;
    !cfg_reg[CF_OUT_EN] |=> !dac_enable ##1 (dac_v_code == 16'h0000 && dac_i_code == 16'h0000);
  endproperty
  a_enable: assert property (p_enable) else $error("output active while disabled");
  property p_cal_lock;
    (wr_cfg && lock_reg[LK_CAL]) |=> cfg_reg[CF_CAL_CUR] == $past(cfg_reg[CF_CAL_CUR]);
  endproperty
  a_cal_lock: assert property (p_cal_lock) else $error("locked target changed");
  property p_relay;
    (rmap == 2'h2) |=> relay[0] == $past(sp_active[2]) && relay[3] == $past(sp_active[1]);
  endproperty
  a_relay: assert property (p_relay) else $error("relay routing wrong");
  c_view_max: cover property (view_reg == VIEW_LIVE ##1 view_reg == VIEW_MAX);
  c_restart: cover property (restart ##1 meas_valid ##1 track_valid_reg);
  c_solved: cover property (pt_wr_reg ##[1:40] cal_if.ready);
endmodule
`default_nettype wire

// File: sim/pvao_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
module pvao_conv_model (
  input wire logic clk, // system clock
  input wire logic enable, // output active
  input wire logic [15:0] v_code, // voltage code
  input wire logic [15:0] i_code, // current code
  output logic [15:0] v_level, // voltage level held
  output logic [15:0] i_level // current level held
);
  // disabled board drops to zero, never keeps the last code
  always_ff @(posedge clk) begin
    v_level <= enable ? v_code : 16'h0000;
    i_level <= enable ? i_code : 16'h0000;
  end
endmodule
`default_nettype wire

// File: sim/peak_valley_analog_out_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module peak_valley_analog_out_ctrl_tb;
  import pvao_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, meas_valid, run_mode, disp_flash, dac_enable, cal_cur;
  logic [3:0] reg_addr, sp_active, relay;
  logic [4:0] key_pin;
  logic [15:0] reg_wdata, reg_rdata, meas_raw, meas_filt, disp_value, bcd_value;
  logic [15:0] v_code, i_code, v_level, i_level;
  int error_cnt, num_checks;
  pvao_top dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas_raw(meas_raw), .meas_filt(meas_filt), .run_mode(run_mode), .key_pin(key_pin),
    .sp_active(sp_active), .disp_value(disp_value), .disp_flash(disp_flash),
    .bcd_value(bcd_value), .dac_enable(dac_enable), .dac_v_code(v_code),
    .dac_i_code(i_code), .dac_cal_current(cal_cur), .relay(relay));
  pvao_conv_model conv (.clk(clk), .enable(dac_enable), .v_code(v_code), .i_code(i_code),
    .v_level(v_level), .i_level(i_level));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(n, reg_rdata, e);
  endtask
  task automatic meas(input logic [15:0] v);
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_raw <= v;
    @(posedge clk);
    meas_valid <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  // held long enough to pass the key synchroniser
  task automatic key(input int k);
    @(posedge clk);
    key_pin[k] <= 1'b1;
    repeat (6) @(posedge clk);
    key_pin[k] <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic s_regs();
    sp_active <= 4'h6;
    rd("lock", REG_LOCK, 16'h001f);
    rd("cfg", REG_CFG, 16'h0000);
    wr(REG_HIGH_DISP, 16'h2000);
    rd("hdisp", REG_HIGH_DISP, 16'h1000);
    wr(REG_CFG, 16'h0002);
    rd("cfg", REG_CFG, 16'h0000);
    chk("relay", 16'(relay), 16'h0006);
  endtask
  task automatic s_track();
    meas(16'h0100);
    rd("max", REG_MAX, 16'h0100);
    rd("min", REG_MIN, 16'h0100);
    meas(16'h0200);
    meas(16'h0050);
    wr(REG_MAX, 16'h0000);
    rd("max", REG_MAX, 16'h0200);
    rd("min", REG_MIN, 16'h0050);
    chk("bcd", bcd_value, 16'h0050);
  endtask
  task automatic s_view();
    @(posedge clk);
    run_mode <= 1'b1;
    key(KEY_UP);
    chk("flash", 16'(disp_flash), 16'h0000);
    wr(REG_LOCK, 16'h0000);
    key(KEY_UP);
    chk("flash", 16'(disp_flash), 16'h0001);
    chk("disp", disp_value, 16'h0200);
    meas(16'h0300);
    chk("disp", disp_value, 16'h0300);
    key(KEY_MENU);
    chk("flash", 16'(disp_flash), 16'h0000);
    rd("max", REG_MAX, 16'h0300);
    key(KEY_DOWN);
    chk("disp", disp_value, 16'h0050);
    meas(16'h0040);
    chk("disp", disp_value, 16'h0040);
    key(KEY_RESET);
    chk("flash", 16'(disp_flash), 16'h0000);
    meas(16'h0120);
    meas(16'h0080);
    rd("min", REG_MIN, 16'h0080);
  endtask
  // default points give unity scale, so codes equal the source value
  task automatic s_out();
    logic [15:0] exp [4] = '{16'h0070, 16'h0040, 16'h0120, 16'h0080};
    @(posedge clk);
    meas_raw <= 16'h0070;
    meas_filt <= 16'h0040;
    // voltage zero trim must land on the calibrated output only
    wr(REG_VZ, 16'h0010);
    for (int s = 0; s < 4; s++) begin
      wr(REG_CFG, 16'(4 * s + 1));
      settle();
      chk("enable", 16'(dac_enable), 16'h0001);
      chk("v_code", v_code, exp[s] + 16'h0010);
      chk("i_code", i_code, exp[s]);
      chk("v_level", v_level, exp[s] + 16'h0010);
    end
    // current becomes the calibrated side, voltage drops its trim
    wr(REG_CFG, 16'h000f);
    settle();
    chk("cal_cur", 16'(cal_cur), 16'h0001);
    chk("v_code", v_code, 16'h0080);
    @(posedge clk);
    meas_raw <= 16'hff00;
    wr(REG_CFG, 16'h0001);
    settle();
    chk("i_code", i_code, 16'h0000);
    chk("v_code", v_code, 16'h0010);
    wr(REG_CFG, 16'h0030);
    sp_active <= 4'h1;
    settle();
    chk("enable", 16'(dac_enable), 16'h0000);
    chk("v_level", v_level, 16'h0000);
    chk("bcd", bcd_value, 16'h0120);
    chk("relay", 16'(relay), 16'h0004);
    wr(REG_CFG, 16'h0050);
    sp_active <= 4'h4;
    settle();
    chk("relay", 16'(relay), 16'h0001);
    wr(REG_CFG, 16'h0070);
    settle();
    chk("relay", 16'(relay), 16'h0004);
    // doubling the high output point doubles the slope
    wr(REG_HIGH_OUT, 16'h2000);
    repeat (40) @(posedge clk);
    rd("scale", REG_SCALE, 16'h0200);
    rd("offset", REG_OFFSET, 16'h0000);
  endtask
  // main sequence
  initial begin
    nrst = 1'b0;
    {reg_wr, reg_rd, meas_valid, run_mode} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    meas_raw = 16'h0000;
    meas_filt = 16'h0000;
    key_pin = 5'h00;
    sp_active = 4'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (40) @(posedge clk);
    s_regs();
    s_track();
    s_view();
    s_out();
    end_sim();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
